// [rtl/bdtc_pkg.sv]
package bdtc_pkg;

  // Configuration space location and reset image of the bridge control register.
  localparam logic [7:0]  BDTC_BRIDGE_CONTROL_OFFSET = 8'h3e;
  localparam logic [15:0] BDTC_BRIDGE_CONTROL_RESET  = 16'h0000;

  // Field positions inside the bridge control register.
  localparam int BDTC_RSVD_HI_BIT      = 15;
  localparam int BDTC_RSVD_LO_BIT      = 12;
  localparam int BDTC_ERR_EN_BIT       = 11;
  localparam int BDTC_FLAG_BIT         = 10;
  localparam int BDTC_SEC_LEN_BIT      = 9;
  localparam int BDTC_PRI_LEN_BIT      = 8;
  localparam int BDTC_UPPER_LANE       = 1;

  // Discard timer lengths, as powers of two of PCI clock cycles.
  localparam int BDTC_LONG_EXP         = 15;
  localparam int BDTC_SHORT_EXP        = 10;
  localparam int BDTC_LONG_CYCLES      = 1 << BDTC_LONG_EXP;
  localparam int BDTC_SHORT_CYCLES     = 1 << BDTC_SHORT_EXP;
  localparam int BDTC_CNT_W            = 16;

  // Delayed completion tracking states.
  typedef enum logic {
    BDTC_IDLE,
    BDTC_ARMED
  } bdtc_state_type;

endpackage

// [rtl/bdtc_discard_counter.sv]
`timescale 1ns/10ps

module bdtc_discard_counter
  import bdtc_pkg::*;
#(
  parameter int LONG_CYCLES  = BDTC_LONG_CYCLES,
  parameter int SHORT_CYCLES = BDTC_SHORT_CYCLES
) (
  input  wire logic mclk,     // PCI clock, 20 MHz.
  input  wire logic nrst,     // Asynchronous reset, active low.
  input  wire logic start,    // Load and run the timer.
  input  wire logic stop,     // Halt the timer without expiry.
  input  wire logic shortSel, // High selects the short length.
  output logic      expire,   // One-cycle pulse when the timer runs out.
  output logic      running   // High while the timer counts.
);

  typedef struct packed {
    logic [BDTC_CNT_W-1:0] cnt;
    logic                  running;
    logic                  expire;
  } bdtc_cnt_state_type;

  bdtc_cnt_state_type cntState_reg;
  bdtc_cnt_state_type cntState_next;

  localparam logic [BDTC_CNT_W-1:0] LONG_LOAD  = BDTC_CNT_W'(LONG_CYCLES - 1);
  localparam logic [BDTC_CNT_W-1:0] SHORT_LOAD = BDTC_CNT_W'(SHORT_CYCLES - 1);

  // Stop wins over expiry; a start reloads the full length.
  always_comb begin
    cntState_next        = cntState_reg;
    cntState_next.expire = 1'b0;
    if (start) begin
      cntState_next.cnt     = shortSel ? SHORT_LOAD : LONG_LOAD;
      cntState_next.running = 1'b1;
    end else if (cntState_reg.running) begin
      if (stop) begin
        cntState_next.running = 1'b0;
      end else if (cntState_reg.cnt == '0) begin
        cntState_next.running = 1'b0;
        cntState_next.expire  = 1'b1;
      end else begin
        cntState_next.cnt = cntState_reg.cnt - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cntState_reg <= '0;
    end else begin
      cntState_reg <= cntState_next;
    end
  end

  assign expire  = cntState_reg.expire;
  assign running = cntState_reg.running;

  property p_load_length;
    @(posedge mclk) disable iff (!nrst)
    start |=> (cntState_reg.cnt == ($past(shortSel) ? SHORT_LOAD : LONG_LOAD)) && cntState_reg.running;
  endproperty
  a_load_length: assert property (p_load_length) else $error("Timer loaded a wrong length.");

  property p_stop_quiet;
    @(posedge mclk) disable iff (!nrst)
    (running && stop && !start) |=> !running && !expire;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("Stopped timer still ran or expired.");

endmodule

// [rtl/bdtc_bridge_ctrl.sv]
// Behaviour
// - Bits 15 to 12 of bridge control always read as zero.
// - With enable set, a discard sends an error message upstream.
// - Message is non-fatal unless advanced error reporting allows fatal selection.
// - The enable bit only acts in conventional PCI mode.
// - Enable clear suppresses message, unless reporting supported and mask bit clear.
// - Discard sets the status flag; software clears it by writing one.
// - Length select zero gives 2^15 cycles, one gives 2^10 cycles.
// - Timer starts when the delayed completion reaches the queue head.
// - On expiry the delayed transaction is deleted and the flag set.
// - Bit 8 is fixed at zero and ignores writes.
`timescale 1ns/10ps

module bdtc_bridge_ctrl
  import bdtc_pkg::*;
#(
  parameter int LONG_CYCLES   = BDTC_LONG_CYCLES,
  parameter int SHORT_CYCLES  = BDTC_SHORT_CYCLES,
  parameter bit AER_SUPPORTED = 1'b1
) (
  input  wire logic        mclk,             // PCI clock, 20 MHz.
  input  wire logic        nrst,             // Asynchronous reset, active low.
  input  wire logic [7:0]  cfgAddr,          // Configuration byte address.
  input  wire logic        cfgRead,          // Configuration read strobe.
  input  wire logic        cfgWrite,         // Configuration write strobe.
  input  wire logic [1:0]  cfgByteEn,        // Byte enables for the 16-bit word.
  input  wire logic [15:0] cfgWdata,         // Write data.
  output logic      [15:0] cfgRdata,         // Read data, valid with cfgRdValid.
  output logic             cfgRdValid,       // Read answer pulse.
  input  wire logic        convPciMode,      // High in conventional PCI mode.
  input  wire logic        aerDiscardMask,   // Discard-timer mask bit of the error mask register.
  input  wire logic        aerFatalSelect,   // Severity select from error reporting logic.
  input  wire logic        completionAtHead, // Delayed completion reached the queue head.
  input  wire logic        masterRepeat,     // Secondary master repeated the request.
  output logic             repeatServed,     // Pulse: completion handed to the master.
  output logic             discardDrop,      // Pulse: delete delayed transaction from queue.
  output logic             errMsgValid,      // Pulse: send error message upstream.
  output logic             errMsgFatal,      // Severity of the message, high for fatal.
  output logic             timerRunning      // Discard timer is counting.
);

  typedef struct packed {
    bdtc_state_type dtState;
    logic           errEnable;
    logic           flag;
    logic           lenSelect;
    logic [15:0]    rdata;
    logic           rdValid;
    logic           served;
    logic           drop;
    logic           msgValid;
    logic           msgFatal;
    logic           running;
  } bdtc_state_reg_type;

  bdtc_state_reg_type st_reg;
  bdtc_state_reg_type st_next;

  logic cntStart;
  logic cntStop;
  logic cntExpire;
  logic cntRunning;
  logic regHit;
  logic upperWrite;
  logic sendMsg;

  // Assemble the readable image of the register from the stored fields.
  function automatic logic [15:0] bdtc_image(input logic en, input logic fl, input logic len);
    logic [15:0] img;
    img                   = BDTC_BRIDGE_CONTROL_RESET;
    img[BDTC_ERR_EN_BIT]  = en;
    img[BDTC_FLAG_BIT]    = fl;
    img[BDTC_SEC_LEN_BIT] = len;
    return img;
  endfunction

  // Register decode; only the upper byte lane carries stored fields.
  always_comb begin
    if (cfgAddr == BDTC_BRIDGE_CONTROL_OFFSET) begin
      regHit = 1'b1;
    end else begin
      regHit = 1'b0;
    end
  end

  assign upperWrite = cfgWrite && regHit && cfgByteEn[BDTC_UPPER_LANE];

  // Timer control follows the tracking state directly.
  assign cntStart = (st_reg.dtState == BDTC_IDLE) && completionAtHead;
  assign cntStop  = (st_reg.dtState == BDTC_ARMED) && masterRepeat && !cntExpire;

  // Message gating: enable counts only in conventional mode, mask path only with reporting.
  assign sendMsg = (st_reg.errEnable && convPciMode) ||
                   (AER_SUPPORTED && !aerDiscardMask);

  bdtc_discard_counter #(
    .LONG_CYCLES  (LONG_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  ) u_counter (
    .mclk     (mclk),
    .nrst     (nrst),
    .start    (cntStart),
    .stop     (cntStop),
    .shortSel (st_reg.lenSelect),
    .expire   (cntExpire),
    .running  (cntRunning)
  );

  // Next state: register writes, read answers, tracking and message generation.
  always_comb begin
    st_next          = st_reg;
    st_next.rdValid  = 1'b0;
    st_next.served   = 1'b0;
    st_next.drop     = 1'b0;
    st_next.msgValid = 1'b0;
    st_next.running  = cntRunning;

    // Stored fields; bit 8 and bits 15:12 have no storage at all.
    if (upperWrite) begin
      st_next.errEnable = cfgWdata[BDTC_ERR_EN_BIT];
      st_next.lenSelect = cfgWdata[BDTC_SEC_LEN_BIT];
      if (cfgWdata[BDTC_FLAG_BIT]) begin
        st_next.flag = 1'b0;
      end
    end

    // Tracking of the one outstanding delayed completion.
    case (st_reg.dtState)
      BDTC_IDLE: begin
        if (completionAtHead) begin
          st_next.dtState = BDTC_ARMED;
        end
      end
      BDTC_ARMED: begin
        if (cntExpire) begin
          st_next.dtState  = BDTC_IDLE;
          st_next.drop     = 1'b1;
          st_next.flag     = 1'b1;
          st_next.msgValid = sendMsg;
          st_next.msgFatal = AER_SUPPORTED && aerFatalSelect;
        end else if (masterRepeat) begin
          st_next.dtState = BDTC_IDLE;
          st_next.served  = 1'b1;
        end
      end
      default: begin
        st_next.dtState = BDTC_IDLE;
      end
    endcase

    // Read answer one cycle after the strobe; unmapped addresses read zero.
    if (cfgRead) begin
      st_next.rdValid = 1'b1;
      if (regHit) begin
        st_next.rdata = bdtc_image(st_reg.errEnable, st_reg.flag, st_reg.lenSelect);
      end else begin
        st_next.rdata = 16'h0000;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign cfgRdata     = st_reg.rdata;
  assign cfgRdValid   = st_reg.rdValid;
  assign repeatServed = st_reg.served;
  assign discardDrop  = st_reg.drop;
  assign errMsgValid  = st_reg.msgValid;
  assign errMsgFatal  = st_reg.msgFatal;
  assign timerRunning = st_reg.running;

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!nrst)
    cfgRdValid |-> (cfgRdata[BDTC_RSVD_HI_BIT:BDTC_RSVD_LO_BIT] == 4'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits read nonzero.");

  property p_pri_zero;
    @(posedge mclk) disable iff (!nrst)
    cfgRdValid |-> !cfgRdata[BDTC_PRI_LEN_BIT];
  endproperty
  a_pri_zero: assert property (p_pri_zero) else $error("Bit 8 read as one.");

  property p_msg_enabled;
    @(posedge mclk) disable iff (!nrst)
    (st_reg.dtState == BDTC_ARMED && cntExpire && st_reg.errEnable && convPciMode) |=> errMsgValid && discardDrop;
  endproperty
  a_msg_enabled: assert property (p_msg_enabled) else $error("Enabled discard sent no message.");

  property p_severity;
    @(posedge mclk) disable iff (!nrst)
    errMsgValid |-> (errMsgFatal == (AER_SUPPORTED && $past(aerFatalSelect)));
  endproperty
  a_severity: assert property (p_severity) else $error("Discard message carried the wrong severity.");

  property p_mode_gate;
    @(posedge mclk) disable iff (!nrst)
    (cntExpire && !convPciMode && !(AER_SUPPORTED && !aerDiscardMask)) |=> !errMsgValid;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("Message sent outside conventional mode.");

  property p_suppress;
    @(posedge mclk) disable iff (!nrst)
    (cntExpire && !st_reg.errEnable && (!AER_SUPPORTED || aerDiscardMask)) |=> !errMsgValid;
  endproperty
  a_suppress: assert property (p_suppress) else $error("Message not suppressed.");

  property p_flag_set;
    @(posedge mclk) disable iff (!nrst)
    discardDrop |-> st_reg.flag ##1 (st_reg.flag || $past(upperWrite));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Discard did not set the flag.");

  property p_msg_needs_drop;
    @(posedge mclk) disable iff (!nrst)
    errMsgValid |-> discardDrop && $past(cntExpire);
  endproperty
  a_msg_needs_drop: assert property (p_msg_needs_drop) else $error("Message without a discard.");

  property p_start_at_head;
    @(posedge mclk) disable iff (!nrst)
    $rose(timerRunning) |-> $past(completionAtHead, 2) && ($past(st_reg.dtState, 2) == BDTC_IDLE);
  endproperty
  a_start_at_head: assert property (p_start_at_head) else $error("Timer started without a completion.");

  property p_served_quiet;
    @(posedge mclk) disable iff (!nrst)
    repeatServed |-> !discardDrop && (st_reg.flag == $past(st_reg.flag) || $past(upperWrite));
  endproperty
  a_served_quiet: assert property (p_served_quiet) else $error("Repeat disturbed the flag.");

  // A discard is a single pulse for each delayed transaction.
  property p_drop_pulse;
    @(posedge mclk) disable iff (!nrst)
    discardDrop |=> !discardDrop;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse) else $error("Discard pulse lasted two cycles.");

  // The timer has already stopped when its discard is signalled.
  property p_drop_idle_timer;
    @(posedge mclk) disable iff (!nrst)
    discardDrop |-> !timerRunning;
  endproperty
  a_drop_idle_timer: assert property (p_drop_idle_timer) else $error("Timer still ran at the discard.");

  // The status flag only rises together with a discard.
  property p_flag_source;
    @(posedge mclk) disable iff (!nrst)
    $rose(st_reg.flag) |-> discardDrop;
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("Flag rose without a discard.");

  // Writing one to the flag clears it unless a discard lands in the same cycle.
  property p_flag_clear;
    @(posedge mclk) disable iff (!nrst)
    (upperWrite && cfgWdata[BDTC_FLAG_BIT] && !(st_reg.dtState == BDTC_ARMED && cntExpire)) |=> !st_reg.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag survived its clear.");

  // A write to the upper lane stores the enable and length bits as written.
  property p_field_store;
    @(posedge mclk) disable iff (!nrst)
    upperWrite |=> (st_reg.errEnable == $past(cfgWdata[BDTC_ERR_EN_BIT])) &&
                   (st_reg.lenSelect == $past(cfgWdata[BDTC_SEC_LEN_BIT]));
  endproperty
  a_field_store: assert property (p_field_store) else $error("Upper lane write not stored.");

  // Without an upper lane write the enable and length bits keep their values.
  property p_field_hold;
    @(posedge mclk) disable iff (!nrst)
    !upperWrite |=> $stable(st_reg.errEnable) && $stable(st_reg.lenSelect);
  endproperty
  a_field_hold: assert property (p_field_hold) else $error("Stored field changed without a write.");

  // A timely repeat is served at once and the timer stops behind it.
  property p_served_timing;
    @(posedge mclk) disable iff (!nrst)
    (st_reg.dtState == BDTC_ARMED && masterRepeat && !cntExpire) |=> repeatServed ##1 !timerRunning;
  endproperty
  a_served_timing: assert property (p_served_timing) else $error("Repeat not served in time.");

  // The timer only runs while a delayed completion is being tracked.
  property p_run_armed;
    @(posedge mclk) disable iff (!nrst)
    timerRunning |-> ($past(st_reg.dtState) == BDTC_ARMED);
  endproperty
  a_run_armed: assert property (p_run_armed) else $error("Timer ran with nothing tracked.");

  // Every read strobe is answered in the next cycle.
  property p_rd_answer;
    @(posedge mclk) disable iff (!nrst)
    cfgRead |=> cfgRdValid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read strobe got no answer.");

  // Reads of any other address return all zeros.
  property p_rd_unmapped;
    @(posedge mclk) disable iff (!nrst)
    (cfgRead && !regHit) |=> (cfgRdata == 16'h0000);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read returned nonzero.");

endmodule

// [tb/bdtc_far_model.sv]
`timescale 1ns/10ps

module bdtc_far_model (
  input  wire logic mclk,             // PCI clock, 20 MHz.
  output logic      completionAtHead, // Delayed completion ready at the queue head.
  output logic      masterRepeat      // Secondary master repeats its request.
);
  // Both request lines rest low outside an offer.
  initial begin
    completionAtHead = 1'b0;
    masterRepeat     = 1'b0;
  end

  // Presents one completion, then repeats the request after repeatAt cycles, or never when zero.
  task automatic offer(input int repeatAt);
    @(negedge mclk);
    completionAtHead = 1'b1;
    @(negedge mclk);
    completionAtHead = 1'b0;
    if (repeatAt > 0) begin
      repeat (repeatAt) @(negedge mclk);
      masterRepeat = 1'b1;
      @(negedge mclk);
      masterRepeat = 1'b0;
    end
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
  import bdtc_pkg::*;
  localparam int LONG_L  = 64;
  localparam int SHORT_L = 16;
  typedef struct {logic [7:0] addr; logic [1:0] be; logic [15:0] wdata; logic [15:0] exp;} bdtc_reg_row_type;
  typedef struct {logic sel; logic en; logic conv; logic mask; logic fatal;} bdtc_drop_row_type;

  logic        mclk = 1'b0;
  logic        nrst, cfgRead, cfgWrite, cfgRdValid, convPciMode, aerDiscardMask, aerFatalSelect;
  logic        completionAtHead, masterRepeat, repeatServed, discardDrop, errMsgValid, errMsgFatal, timerRunning;
  logic [7:0]  cfgAddr;
  logic [1:0]  cfgByteEn;
  logic [15:0] cfgWdata, cfgRdata;
  int          errCount = 0;
  int          nTests   = 0;
  int          rstDrop  = 0;

  // Writes to the upper lane, a write to the low lane only, and a write elsewhere, each read back.
  bdtc_reg_row_type regRows[5] = '{'{8'h3e, 2'b10, 16'hffff, 16'h0a00}, '{8'h3e, 2'b01, 16'h0000, 16'h0a00},
    '{8'h3d, 2'b10, 16'h0000, 16'h0a00}, '{8'h3e, 2'b10, 16'h0200, 16'h0200}, '{8'h3e, 2'b10, 16'h0000, 16'h0000}};
  // Length, enable, mode, mask and severity settings for timer runs that end in a discard.
  bdtc_drop_row_type dropRows[5] = '{'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0}, '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
    '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};

  // The clock toggles every half period of 25 ns.
  always #25 mclk = ~mclk;

  bdtc_bridge_ctrl #(.LONG_CYCLES(LONG_L), .SHORT_CYCLES(SHORT_L), .AER_SUPPORTED(1'b1)) bdtc_bridge_ctrl_i (
    .mclk(mclk), .nrst(nrst), .cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid), .convPciMode(convPciMode),
    .aerDiscardMask(aerDiscardMask), .aerFatalSelect(aerFatalSelect), .completionAtHead(completionAtHead),
    .masterRepeat(masterRepeat), .repeatServed(repeatServed), .discardDrop(discardDrop),
    .errMsgValid(errMsgValid), .errMsgFatal(errMsgFatal), .timerRunning(timerRunning));

  bdtc_far_model far_i (.mclk(mclk), .completionAtHead(completionAtHead), .masterRepeat(masterRepeat));

  // Prints the verdict once and ends the run.
  task automatic printVerdict();
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write strobe, held for a single clock edge.
  task automatic cfgWr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge mclk);
    cfgAddr = a; cfgByteEn = be; cfgWdata = d; cfgWrite = 1'b1;
    @(negedge mclk);
    cfgWrite = 1'b0;
  endtask

  // One read strobe; the answer stands for the one cycle right after the taking edge.
  task automatic cfgRd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk);
    cfgAddr = a; cfgRead = 1'b1;
    @(negedge mclk);
    cfgRead = 1'b0;
    chk("cfgRdValid", 16'h0001, {15'h0, cfgRdValid});
    chk("cfgRdata", exp, cfgRdata);
  endtask

  // Arms the timer through the far side and watches drop, message and service until past expiry.
  task automatic dropRun(input bdtc_drop_row_type r, input int repeatAt);
    int          len;
    int          dropAt;
    logic        msg;
    logic        fat;
    logic        served;
    logic [15:0] cfg;
    len = r.sel ? SHORT_L : LONG_L;
    dropAt = 0; msg = 1'b0; fat = 1'b0; served = 1'b0;
    cfg = {4'h0, r.en, 1'b1, r.sel, 9'h000};
    cfgWr(8'h3e, 2'b10, cfg);
    convPciMode = r.conv; aerDiscardMask = r.mask; aerFatalSelect = r.fatal;
    fork
      far_i.offer(repeatAt);
      begin
        @(negedge mclk);
        for (int i = 1; i <= len + 4; i++) begin
          @(negedge mclk);
          if (i == 2) chk("timerRunning", 16'h0001, {15'h0, timerRunning});
          if (discardDrop === 1'b1 && dropAt == 0) dropAt = i;
          if (errMsgValid === 1'b1) begin
            msg = 1'b1;
            fat = errMsgFatal;
          end
          if (repeatServed === 1'b1) served = 1'b1;
        end
      end
    join
    cfg[10] = 1'b0;
    if (repeatAt > 0) begin
      chk("repeatServed", 16'h0001, {15'h0, served});
      chk("dropCycle", 16'h0000, 16'(dropAt));
      chk("errMsgValid", 16'h0000, {15'h0, msg});
      cfgRd(8'h3e, cfg);
    end else begin
      chk("dropCycle", 16'(len + 2), 16'(dropAt));
      chk("errMsgValid", {15'h0, (r.en & r.conv) | ~r.mask}, {15'h0, msg});
      if (msg) chk("errMsgFatal", {15'h0, r.fatal}, {15'h0, fat});
      cfgRd(8'h3e, cfg | 16'h0400);
    end
  endtask

  // Main sequence: reset, register table, discard table, then a timely repeat.
  initial begin
    nrst = 1'b0; cfgAddr = 8'h00; cfgRead = 1'b0; cfgWrite = 1'b0; cfgByteEn = 2'b00; cfgWdata = 16'h0000;
    convPciMode = 1'b0; aerDiscardMask = 1'b1; aerFatalSelect = 1'b0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    cfgRd(8'h3e, BDTC_BRIDGE_CONTROL_RESET);
    foreach (regRows[k]) begin
      cfgWr(regRows[k].addr, regRows[k].be, regRows[k].wdata);
      cfgRd(8'h3e, regRows[k].exp);
    end
    cfgRd(8'h3c, 16'h0000);
    foreach (dropRows[k]) dropRun(dropRows[k], 0);
    dropRun('{1'b1, 1'b0, 1'b1, 1'b1, 1'b0}, 5);
    // Reset in mid-run while the timer counts: nothing is discarded later and the register is back at zero.
    cfgWr(8'h3e, 2'b10, 16'h0a00);
    far_i.offer(0);
    repeat (3) @(negedge mclk);
    nrst = 1'b0;
    @(negedge mclk);
    chk("timerRunning", 16'h0000, {15'h0, timerRunning});
    nrst = 1'b1;
    for (int i = 1; i <= SHORT_L + 4; i++) begin
      @(negedge mclk);
      if (discardDrop === 1'b1) rstDrop = i;
    end
    chk("dropCycle", 16'h0000, 16'(rstDrop));
    cfgRd(8'h3e, BDTC_BRIDGE_CONTROL_RESET);
    printVerdict();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge mclk);
    errCount++;
    printVerdict();
  end
endmodule
